// file: hdl/spi_status_defs.svh
`ifndef SPI_STATUS_DEFS_SVH
`define SPI_STATUS_DEFS_SVH

// Command byte layout.
`define CMD_TOGGLE      7
`define CMD_ADDR        6:4
`define CMD_DATA        3:0
`define CMD_PAIR        1:0
`define CMD_SEL         2:0
`define CMD_ON_BIT      0

// Register addresses carried in bits 6 to 4 of a command.
`define ADDR_READBACK   3'h0
`define ADDR_OUTPUT     3'h1
`define ADDR_OC_LEVEL   3'h2
`define ADDR_TIMING     3'h3
`define ADDR_DIRECT     3'h4
`define ADDR_DELAY_WD   3'h5
`define ADDR_NOACT_UOV  3'h6
`define ADDR_TEST       3'h7

// Reset values.
`define SEL_RESET       4'h7
`define CONFIG_RESET    22'h000000
`define FAULT_RESET     7'h00
`define COUNT_RESET     3'h0

// Fault vector positions, matching status bits 6 to 1.
`define FLT_WIDTH       6
`define FLT_OVERTEMP    5
`define FLT_OC_HIGH     4
`define FLT_OC_LOW      3
`define FLT_OPEN_LOAD   2
`define FLT_UNDERVOLT   1
`define FLT_OVERVOLT    0
`define FLT_LATCHED     6'h18

// Synchronised pin vector positions.
`define PIN_COUNT       6
`define PIN_CS          5
`define PIN_SCLK        4
`define PIN_SI          3
`define PIN_IN          2
`define PIN_FSI         1
`define PIN_WAKE        0
`define PIN_RESET       6'h20

`endif

// file: hdl/spi_status_pkg.sv
package spi_status_pkg;

`include "spi_status_defs.svh"

    typedef enum logic {
        LINK_IDLE  = 1'b0,
        LINK_FRAME = 1'b1
    } link_state_t;

    typedef struct packed {
        logic       page;
        logic [2:0] code;
    } select_t;

    typedef struct packed {
        logic       current_sense_enable;
        logic       output_on;
        logic       high_overcurrent_level;
        logic [2:0] low_overcurrent_level;
        logic       open_load_disable;
        logic       overcurrent_timeout_disable;
        logic [1:0] blanking_time_code;
        logic       fast_slew_select;
        logic       high_sense_ratio_select;
        logic       direct_input_disable;
        logic       and_combine_select;
        logic       failsafe_output_state;
        logic [2:0] turn_on_delay_code;
        logic [1:0] watchdog_period_code;
        logic       undervoltage_protection_disable;
        logic       overvoltage_protection_disable;
    } config_t;

endpackage

// file: hdl/pin_sync.sv
`timescale 1ns/1ns

module pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] level
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // Stage one feeds stage two only; a change is believed once two and three agree.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            stage1 <= INIT;
            stage2 <= INIT;
            stage3 <= INIT;
        end else begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    level[i] <= INIT[i];
                end else if (stage2[i] == stage3[i]) begin
                    level[i] <= stage3[i];
                end
            end
        end
    endgenerate

endmodule

// file: hdl/fault_latch.sv
`timescale 1ns/1ns

module fault_latch #(
    parameter int               WIDTH   = 6,
    parameter logic [WIDTH-1:0] LATCHED = '0
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic             accept,
    input  wire logic [WIDTH-1:0] event_in,
    input  wire logic             clear,
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] pending;
    logic             clear_held;

    // A clear that lands while the flags are frozen waits for the next update.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clear_held <= 1'b0;
        end else begin
            clear_held <= ~accept & (clear_held | clear);
        end
    end

    wire clear_now = clear | clear_held;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_flag
            if (LATCHED[i]) begin : g_sticky
                // Events during a frame wait in pending so none is lost; set beats clear.
                always_ff @(posedge clk or negedge reset_n) begin
                    if (!reset_n) begin
                        flags[i]   <= 1'b0;
                        pending[i] <= 1'b0;
                    end else if (accept) begin
                        flags[i]   <= event_in[i] | pending[i] | (flags[i] & ~clear_now);
                        pending[i] <= 1'b0;
                    end else begin
                        pending[i] <= pending[i] | event_in[i];
                    end
                end
            end else begin : g_live
                assign pending[i] = 1'b0;
                always_ff @(posedge clk or negedge reset_n) begin
                    if (!reset_n) begin
                        flags[i] <= 1'b0;
                    end else if (accept) begin
                        flags[i] <= event_in[i];
                    end
                end
            end
        end
    endgenerate

endmodule

// file: hdl/spi_status_readback.sv
`timescale 1ns/1ns
`include "spi_status_defs.svh"

// How it works
// - Falling chip select loads the selected status word into the shift register.
// - Status leaves MSB first on SO while SI bits shift in.
// - After eight bits, SO echoes the SI bits received this frame, in order.
// - Rising chip select commits the command only for a nonzero multiple of eight bits.
// - Rising chip select releases SO and lets fault flags update again.
// - An invalid frame changes nothing: selection, echo and flags stay as before.
// - Status bit 7 echoes the toggle bit of the previous valid command; for codes 101 and 110 it is the sub-page bit.
// - Readback code and sub-page bit of the last select command choose the word.
// - Code 000 returns the six fault flags and the summary flag.
// - Code 001 returns the code, two zeros, sense enable and output-on.
// - Code 010 returns the code, high and low overcurrent levels.
// - Code 011 returns the code, open-load and timeout disables, blanking code.
// - Code 100 returns the code, slew, sense ratio, direct disable, combine select.
// - Code 101 page 0 returns fail-safe output state and turn-on delay code.
// - Code 101 page 1 returns zero, watchdog expired and watchdog period code.
// - Code 110 page 0 returns zero and the live direct, fail-safe, wake pins.
// - Code 110 page 1 returns zeros and both supply protection disables.
// - Code 111, the reset selection, returns null data with low bits zero.
// - Summary fault sets on any fault and clears when a read returns it.
// - Failure output asserts on a fault and releases on a new switch-on.
// - Command bit 7 toggled in output or no-action commands refreshes the watchdog.
module spi_status_readback
    import spi_status_pkg::*;
#(
    parameter logic UV_LATCHED = 1'b0
) (
    input  wire logic    clk,
    input  wire logic    reset_n,
    input  wire logic    cs_n,
    input  wire logic    sclk,
    input  wire logic    si,
    input  wire logic    direct_input,
    input  wire logic    safe_mode_select_input,
    input  wire logic    wake_input,
    input  wire logic    overtemp_event,
    input  wire logic    high_overcurrent_event,
    input  wire logic    low_overcurrent_event,
    input  wire logic    open_load_event,
    input  wire logic    undervoltage_event,
    input  wire logic    overvoltage_event,
    input  wire logic    watchdog_expired,
    output logic         so_out,
    output logic         so_oe,
    output logic         failure_indicator_n,
    output logic         watchdog_refresh,
    output config_t      device_config
);

    localparam logic [`FLT_WIDTH-1:0] LATCH_MASK =
        `FLT_LATCHED | ({{(`FLT_WIDTH-1){1'b0}}, UV_LATCHED} << `FLT_UNDERVOLT);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin sampling and edge detection.

    logic [`PIN_COUNT-1:0] pins;
    logic                  cs_prev;
    logic                  sclk_prev;

    pin_sync #(
        .WIDTH (`PIN_COUNT),
        .INIT  (`PIN_RESET)
    ) u_pin_sync (
        .clk      (clk),
        .reset_n  (reset_n),
        .async_in ({cs_n, sclk, si, direct_input, safe_mode_select_input, wake_input}),
        .level    (pins)
    );

    wire cs_level   = pins[`PIN_CS];
    wire sclk_level = pins[`PIN_SCLK];
    wire si_level   = pins[`PIN_SI];
    wire cs_fall    = cs_prev & ~cs_level;
    wire cs_rise    = ~cs_prev & cs_level;
    // A clock edge counts only inside a frame.
    wire sclk_rise  = ~cs_level & ~cs_prev & ~sclk_prev & sclk_level;
    wire sclk_fall  = ~cs_level & ~cs_prev & sclk_prev & ~sclk_level;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cs_prev   <= 1'b1;
            sclk_prev <= 1'b0;
        end else begin
            cs_prev   <= cs_level;
            sclk_prev <= sclk_level;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame state, shift chain and bit count.

    link_state_t state;
    link_state_t next_state;
    logic [7:0]  shift;
    logic [2:0]  bit_count;
    logic        got_bits;
    logic        read_was_fault;
    logic [7:0]  status_word;

    always_comb begin
        next_state = state;
        unique case (state)
            LINK_IDLE: begin
                if (cs_fall) begin
                    next_state = LINK_FRAME;
                end
            end
            LINK_FRAME: begin
                if (cs_rise) begin
                    next_state = LINK_IDLE;
                end
            end
        endcase
    end

    wire in_frame  = (state == LINK_FRAME);
    wire len_valid = got_bits & (bit_count == `COUNT_RESET);
    wire commit    = in_frame & cs_rise & len_valid;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= LINK_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // The eight-bit chain first holds the status word, then the SI history,
    // so the bit leaving SO after eight clocks is the first bit received.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shift <= 8'h00;
        end else if (cs_fall) begin
            shift <= status_word;
        end else if (in_frame && sclk_rise) begin
            shift <= {shift[6:0], si_level};
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bit_count <= `COUNT_RESET;
            got_bits  <= 1'b0;
        end else if (cs_fall) begin
            bit_count <= `COUNT_RESET;
            got_bits  <= 1'b0;
        end else if (in_frame && sclk_rise) begin
            bit_count <= bit_count + 3'h1;
            got_bits  <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            so_out <= 1'b0;
            so_oe  <= 1'b0;
        end else if (cs_fall) begin
            so_out <= status_word[7];
            so_oe  <= 1'b1;
        end else if (in_frame && cs_rise) begin
            so_oe  <= 1'b0;
        end else if (in_frame && sclk_fall) begin
            so_out <= shift[7];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Command decode on a valid frame end.

    select_t select;
    logic    toggle_echo;

    wire [2:0] cmd_addr  = shift[`CMD_ADDR];
    wire       cmd_page  = shift[`CMD_TOGGLE];
    wire       wr_select = commit & (cmd_addr == `ADDR_READBACK);
    wire       wr_output = commit & (cmd_addr == `ADDR_OUTPUT);
    wire       wr_level  = commit & (cmd_addr == `ADDR_OC_LEVEL);
    wire       wr_timing = commit & (cmd_addr == `ADDR_TIMING);
    wire       wr_direct = commit & (cmd_addr == `ADDR_DIRECT);
    wire       wr_delay  = commit & (cmd_addr == `ADDR_DELAY_WD) & ~cmd_page;
    wire       wr_wdog   = commit & (cmd_addr == `ADDR_DELAY_WD) & cmd_page;
    wire       wr_noact  = commit & (cmd_addr == `ADDR_NOACT_UOV) & ~cmd_page;
    wire       wr_supply = commit & (cmd_addr == `ADDR_NOACT_UOV) & cmd_page;
    wire       spi_on    = wr_output & shift[`CMD_ON_BIT] & ~device_config.output_on;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            select      <= `SEL_RESET;
            toggle_echo <= 1'b0;
        end else if (commit) begin
            toggle_echo <= shift[`CMD_TOGGLE];
            if (wr_select) begin
                select <= {shift[`CMD_TOGGLE], shift[`CMD_SEL]};
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            device_config <= `CONFIG_RESET;
        end else begin
            if (wr_output) begin
                {device_config.current_sense_enable, device_config.output_on} <=
                    shift[`CMD_PAIR];
            end
            if (wr_level) begin
                {device_config.high_overcurrent_level, device_config.low_overcurrent_level} <=
                    shift[`CMD_DATA];
            end
            if (wr_timing) begin
                {device_config.open_load_disable, device_config.overcurrent_timeout_disable,
                 device_config.blanking_time_code} <= shift[`CMD_DATA];
            end
            if (wr_direct) begin
                {device_config.fast_slew_select, device_config.high_sense_ratio_select,
                 device_config.direct_input_disable, device_config.and_combine_select} <=
                    shift[`CMD_DATA];
            end
            if (wr_delay) begin
                {device_config.failsafe_output_state, device_config.turn_on_delay_code} <=
                    shift[`CMD_DATA];
            end
            if (wr_wdog) begin
                device_config.watchdog_period_code <= shift[`CMD_PAIR];
            end
            if (wr_supply) begin
                {device_config.undervoltage_protection_disable,
                 device_config.overvoltage_protection_disable} <= shift[`CMD_PAIR];
            end
        end
    end

    // Only output and no-action commands carry a refresh; a toggle is a change of bit 7.
    wire refresh_now = (wr_output | wr_noact) & (shift[`CMD_TOGGLE] != toggle_echo);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_refresh <= 1'b0;
        end else begin
            watchdog_refresh <= refresh_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Fault flags, summary flag and failure output.

    logic [`FLT_WIDTH-1:0] fault_live;
    logic                  fault_summary;
    logic [2:0]            direct_prev;

    wire [`FLT_WIDTH-1:0] fault_events = {
        overtemp_event,
        high_overcurrent_event,
        low_overcurrent_event,
        open_load_event,
        undervoltage_event & ~device_config.undervoltage_protection_disable,
        overvoltage_event & ~device_config.overvoltage_protection_disable
    };
    wire any_fault   = |fault_events;
    wire direct_rise = pins[`PIN_IN] & ~direct_prev[0] & ~device_config.direct_input_disable;
    wire switch_on   = spi_on | direct_rise;

    // Latched overcurrent flags are cleared by a new switch-on, like the failure output.
    fault_latch #(
        .WIDTH   (`FLT_WIDTH),
        .LATCHED (LATCH_MASK)
    ) u_fault_latch (
        .clk      (clk),
        .reset_n  (reset_n),
        .accept   (~in_frame),
        .event_in (fault_events),
        .clear    (switch_on),
        .flags    (fault_live)
    );

    wire [6:0] fault_flags = {fault_live, fault_summary};

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_summary  <= 1'b0;
            read_was_fault <= 1'b0;
        end else begin
            if (cs_fall) begin
                read_was_fault <= (select.code == `ADDR_READBACK);
            end
            // A fault arriving with the clearing read wins.
            if (any_fault) begin
                fault_summary <= 1'b1;
            end else if (commit && read_was_fault) begin
                fault_summary <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            failure_indicator_n <= 1'b1;
            direct_prev         <= 3'h0;
        end else begin
            direct_prev <= {direct_prev[1:0], pins[`PIN_IN]};
            if (any_fault) begin
                failure_indicator_n <= 1'b0;
            end else if (switch_on) begin
                failure_indicator_n <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status word selection.

    wire       paged     = (select.code == `ADDR_DELAY_WD) | (select.code == `ADDR_NOACT_UOV);
    wire       top_bit   = paged ? select.page : toggle_echo;
    wire [2:0] pin_levels = {pins[`PIN_IN], pins[`PIN_FSI], pins[`PIN_WAKE]};

    wire [3:0] low_output = {2'h0, device_config.current_sense_enable,
                             device_config.output_on};
    wire [3:0] low_level  = {device_config.high_overcurrent_level,
                             device_config.low_overcurrent_level};
    wire [3:0] low_timing = {device_config.open_load_disable,
                             device_config.overcurrent_timeout_disable,
                             device_config.blanking_time_code};
    wire [3:0] low_direct = {device_config.fast_slew_select,
                             device_config.high_sense_ratio_select,
                             device_config.direct_input_disable,
                             device_config.and_combine_select};
    wire [3:0] low_delay  = select.page ?
                            {1'h0, watchdog_expired, device_config.watchdog_period_code} :
                            {device_config.failsafe_output_state,
                             device_config.turn_on_delay_code};
    wire [3:0] low_pins   = select.page ?
                            {2'h0, device_config.undervoltage_protection_disable,
                             device_config.overvoltage_protection_disable} :
                            {1'h0, pin_levels};

    wire [3:0] low_word =
        (select.code == `ADDR_OUTPUT)   ? low_output :
        (select.code == `ADDR_OC_LEVEL) ? low_level  :
        (select.code == `ADDR_TIMING)   ? low_timing :
        (select.code == `ADDR_DIRECT)   ? low_direct :
        (select.code == `ADDR_DELAY_WD) ? low_delay  : low_pins;

    // Null data keeps the echo bit so a chain still sees the refresh history.
    assign status_word =
        (select.code == `ADDR_READBACK) ? {toggle_echo, fault_flags} :
        (select.code == `ADDR_TEST)     ? {toggle_echo, 7'h00}       :
                                          {top_bit, select.code, low_word};

endmodule

// file: tb/spi_status_readback_assertions.sv
`timescale 1ns/1ns
module spi_status_readback_assertions
    import spi_status_pkg::*;
(
    input wire logic    clk,
    input wire logic    reset_n,
    input wire logic    cs_n,
    input wire logic    sclk,
    input wire logic    si,
    input wire logic    direct_input,
    input wire logic    safe_mode_select_input,
    input wire logic    wake_input,
    input wire logic    overtemp_event,
    input wire logic    high_overcurrent_event,
    input wire logic    low_overcurrent_event,
    input wire logic    open_load_event,
    input wire logic    undervoltage_event,
    input wire logic    overvoltage_event,
    input wire logic    watchdog_expired,
    input wire logic    so_out,
    input wire logic    so_oe,
    input wire logic    failure_indicator_n,
    input wire logic    watchdog_refresh,
    input wire config_t device_config
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////
    property p_so_release; cs_n [*8] |-> !so_oe; endproperty
    a_so_release: assert property (p_so_release) else $error("SO driven while idle");
    property p_so_drive; !cs_n [*8] |-> so_oe; endproperty
    a_so_drive: assert property (p_so_drive) else $error("SO not driven in frame");
    property p_so_hold; (!cs_n && $stable(sclk)) [*8] |=> $stable(so_out); endproperty
    a_so_hold: assert property (p_so_hold) else $error("SO moved without a clock");
    property p_cfg_frame; !cs_n [*8] |=> $stable(device_config); endproperty
    a_cfg_frame: assert property (p_cfg_frame) else $error("config moved in frame");
    property p_cfg_idle; cs_n [*8] |=> $stable(device_config); endproperty
    a_cfg_idle: assert property (p_cfg_idle) else $error("config moved while idle");
    property p_fail_set; (overtemp_event && cs_n) [*4] |-> !failure_indicator_n; endproperty
    a_fail_set: assert property (p_fail_set) else $error("failure output not set");
    // The wait of eight cycles lets a committed switch-on land before the hold is judged.
    property p_fail_hold;
        (cs_n && !direct_input) [*8] ##0 !failure_indicator_n |=> !failure_indicator_n;
    endproperty
    a_fail_hold: assert property (p_fail_hold) else $error("failure output dropped");
    property p_refresh; watchdog_refresh |-> cs_n ##1 !watchdog_refresh; endproperty
    a_refresh: assert property (p_refresh) else $error("refresh pulse malformed");
endmodule

bind spi_status_readback spi_status_readback_assertions spi_status_readback_assertions_i (
    .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .si(si),
    .direct_input(direct_input), .safe_mode_select_input(safe_mode_select_input),
    .wake_input(wake_input), .overtemp_event(overtemp_event),
    .high_overcurrent_event(high_overcurrent_event),
    .low_overcurrent_event(low_overcurrent_event), .open_load_event(open_load_event),
    .undervoltage_event(undervoltage_event), .overvoltage_event(overvoltage_event),
    .watchdog_expired(watchdog_expired), .so_out(so_out), .so_oe(so_oe),
    .failure_indicator_n(failure_indicator_n), .watchdog_refresh(watchdog_refresh),
    .device_config(device_config)
);

// file: tb/spi_host_model.sv
`timescale 1ns/1ns
module spi_host_model (
    input  wire logic clk,
    input  wire logic so_out,
    input  wire logic so_oe,
    output logic      cs_n,
    output logic      sclk,
    output logic      si
);
    // Words after a supply shutdown or a reset release with wake low are dropped; this host
    // never meets either, so it keeps every word.
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        si   = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    ////////////////////////////////////////
    // A released SO reads as unknown, so a word taken from an idle pin never matches.
    task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        tick(1);
        cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = tx[i];
            tick(7);
            rx[i] = so_oe ? so_out : 1'bx;
            sclk = 1'b1;
            tick(6);
            sclk = 1'b0;
        end
        si = ~si;
        tick(10);
        cs_n = 1'b1;
        tick(12);
    endtask
    task automatic idle_clocks(input int n);
        repeat (n) begin
            si = ~si;
            sclk = 1'b1;
            tick(6);
            sclk = 1'b0;
            tick(6);
        end
    endtask
endmodule

// file: tb/spi_status_readback_tb.sv
`timescale 1ns/1ns
`define CHECK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end
module spi_status_readback_tb;
    import spi_status_pkg::*;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        direct_input = 1'b1;
    logic        wake_input = 1'b1;
    logic        fsi_level = 1'b1;
    logic        wd_expired = 1'b1;
    int          refresh_seen = 0;
    logic [5:0]  fault_in = 6'h00;
    logic        so_out, so_oe, failure_indicator_n, watchdog_refresh, cs_n, sclk, si;
    config_t     device_config;
    logic [15:0] rx;
    int          num_errors = 0;
    int          tests_run = 0;

    always #5 clk = ~clk;

    always @(negedge clk) begin
        if (watchdog_refresh) begin
            refresh_seen++;
        end
    end

    spi_status_readback spi_status_readback_i (
        .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sclk(sclk), .si(si),
        .direct_input(direct_input), .safe_mode_select_input(fsi_level),
        .wake_input(wake_input), .overtemp_event(fault_in[5]),
        .high_overcurrent_event(fault_in[4]), .low_overcurrent_event(fault_in[3]),
        .open_load_event(fault_in[2]), .undervoltage_event(fault_in[1]),
        .overvoltage_event(fault_in[0]), .watchdog_expired(wd_expired),
        .so_out(so_out), .so_oe(so_oe), .failure_indicator_n(failure_indicator_n),
        .watchdog_refresh(watchdog_refresh), .device_config(device_config)
    );
    spi_host_model spi_host_model_i (
        .clk(clk), .so_out(so_out), .so_oe(so_oe), .cs_n(cs_n), .sclk(sclk), .si(si)
    );
    ////////////////////////////////////////
    task automatic xfer(input logic [15:0] tx, input int n);
        spi_host_model_i.xfer(tx, n, rx);
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Each row but the last writes a setting, selects its readback, then reads it with a no-action frame.
    task automatic t_readback;
        logic [7:0] wr [8] = '{8'h13, 8'h2b, 8'h3d, 8'h4a, 8'h56, 8'hd3, 8'he2, 8'h60};
        logic [7:0] sl [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h85, 8'h86, 8'h06};
        logic [7:0] ex [8] = '{8'h13, 8'h2b, 8'h3d, 8'h4a, 8'h56, 8'hd7, 8'he2, 8'h67};
        xfer(16'h0060, 8);
        `CHECK(rx[7:0], 8'h00)
        foreach (wr[k]) begin
            xfer({8'h00, wr[k]}, 8);
            xfer({8'h00, sl[k]}, 8);
            xfer(16'h0060, 8);
            `CHECK(rx[7:0], ex[k])
        end
        `CHECK(device_config.output_on, 1'b1)
        `CHECK(refresh_seen, 2)
        $display("test readback done");
    endtask
    task automatic t_chain_invalid;
        xfer(16'h5a01, 16);
        `CHECK(rx[15:8], 8'h67)
        `CHECK(rx[7:0], 8'h5a)
        spi_host_model_i.idle_clocks(4);
        xfer(16'h0800, 12);
        `CHECK(rx[11:4], 8'h13)
        `CHECK(rx[3:0], 4'h8)
        `CHECK(so_oe, 1'b0)
        xfer(16'h0060, 8);
        `CHECK(rx[7:0], 8'h13)
        $display("test chain and invalid frame done");
    endtask
    task automatic t_faults;
        int base;
        direct_input = 1'b0;
        xfer(16'h0080, 8);
        fault_in = 6'h30;
        repeat (5) @(negedge clk);
        fault_in = 6'h00;
        `CHECK(failure_indicator_n, 1'b0)
        xfer(16'h0080, 8);
        `CHECK(rx[7:0], 8'ha1)
        base = refresh_seen;
        // Bit 7 flips against the previous command, so this frame refreshes the watchdog.
        xfer(16'h0010, 8);
        `CHECK(rx[7:0], 8'ha0)
        `CHECK(failure_indicator_n, 1'b0)
        `CHECK(refresh_seen - base, 1)
        xfer(16'h0011, 8);
        `CHECK(rx[7:0], 8'h20)
        `CHECK(failure_indicator_n, 1'b1)
        `CHECK(refresh_seen - base, 1)
        xfer(16'h0060, 8);
        `CHECK(rx[7:0], 8'h00)
        $display("test faults done");
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (6) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        t_readback();
        t_chain_invalid();
        t_faults();
        wrap_up();
    end
    initial begin
        repeat (100000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
endmodule
